// ==== shared/pll_fb_div_regs.vh ====
// Register map, field positions and reset values of the divider control
`ifndef PLL_FB_DIV_REGS_VH
`define PLL_FB_DIV_REGS_VH

// Register addresses
`define ADDR_REF_COUNT_LOW 10'h011
`define ADDR_REF_COUNT_HIGH 10'h012
`define ADDR_SWALLOW_COUNT 10'h013
`define ADDR_FEEDBACK_COUNT_LOW 10'h014
`define ADDR_FEEDBACK_COUNT_HIGH 10'h015
`define ADDR_DIVIDER_CONTROL 10'h016
`define ADDR_STATUS_PIN_SELECT 10'h017

// Reset values
`define RST_REF_COUNT_LOW 8'h01
`define RST_REF_COUNT_HIGH 6'h00
`define RST_SWALLOW_COUNT 6'h00
`define RST_FEEDBACK_COUNT_LOW 8'h03
`define RST_FEEDBACK_COUNT_HIGH 5'h00
`define RST_DIVIDER_CONTROL 8'h06
`define RST_STATUS_PIN_SELECT 6'h00

// Divider control fields
`define CTRL_CHARGE_PUMP_HALF_BIT 7
`define CTRL_RST_REF_BIT 6
`define CTRL_RST_FB_BIT 5
`define CTRL_RST_ALL_BIT 4
`define CTRL_BYPASS_BIT 3
`define CTRL_PRESC_MSB 2
`define CTRL_PRESC_LSB 0

// Status pin select field
`define STATUS_SEL_MSB 7
`define STATUS_SEL_LSB 2
`define STATUS_SEL_GROUND 6'h00

// Prescaler codes
`define PRESC_FIXED_1 3'h0
`define PRESC_DUAL_2_3 3'h1
`define PRESC_DUAL_2_3B 3'h2
`define PRESC_DUAL_4_5 3'h3
`define PRESC_DUAL_8_9 3'h4
`define PRESC_DUAL_16_17 3'h5
`define PRESC_DUAL_32_33 3'h6
`define PRESC_FIXED_3 3'h7

`endif

// ==== src/pin_edge_sync.v ====
// Three-stage pin synchroniser with qualified rising-edge pulse
`timescale 1ns/100ps
module pin_edge_sync (
	input wire clk_i,
	input wire sys_rst_i,
	input wire pin_i,
	output wire rise_o
);
	reg s1_q; // First stage, read only by s2
	reg s2_q; // Second stage
	reg s3_q; // Third stage
	reg level_q; // Accepted level
	reg rise_q; // One-cycle edge pulse

	// Synchroniser chain and agreement filter
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
			rise_q <= 1'b0;
		end else begin
			s1_q <= pin_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
			rise_q <= 1'b0;
			// Change counts once stages two and three agree
			if (s2_q == s3_q) begin
				level_q <= s3_q;
				rise_q <= s3_q & ~level_q;
			end
		end
	end

	assign rise_o = rise_q;
endmodule

// ==== src/pll_feedback_divider_control.v ====
// PLL reference and feedback divider configuration and counting logic
`timescale 1ns/100ps
`include "pll_fb_div_regs.vh"

// Behaviour
// - Six-bit swallow count register, resets zero
// - Thirteen-bit feedback count over two registers
// - Control bit 7 forces charge pump mid-supply
// - Control bit 6 holds reference divider reset
// - Control bit 5 holds swallow, feedback reset
// - Control bit 4 holds all counters reset
// - Control bit 3 bypasses feedback counter
// - Prescaler code: 000 div1, 111 div3
// - Dual modulus: high while swallow cycles remain
// - Status select writable only while unlocked
// - Fourteen-bit reference count, resets to one
module pll_feedback_divider_control (
	input wire clk_i,
	input wire sys_rst_i,
	input wire wr_en_i,
	input wire [9:0] addr_i,
	input wire [7:0] wr_data_i,
	output wire [7:0] rd_data_o,
	input wire status_lock_i,
	input wire ref_clk_i,
	input wire osc_clk_i,
	output wire ref_div_o,
	output wire fb_div_o,
	output wire presc_out_o,
	output wire charge_pump_half_o,
	output wire [5:0] status_pin_sel_o,
	output wire status_pin_o
);
	reg [7:0] ref_low_q; // Reference count low byte
	reg [5:0] ref_high_q; // Reference count high bits
	reg [5:0] swallow_q; // Swallow count
	reg [7:0] fb_low_q; // Feedback count low byte
	reg [4:0] fb_high_q; // Feedback count high bits
	reg [7:0] ctrl_q; // Divider control
	reg [5:0] status_sel_q; // Status pin selector
	reg [7:0] rd_data_q; // Read data
	reg [7:0] rd_data_d;
	reg [13:0] ref_cnt_q; // Reference divider state
	reg ref_div_q; // Reference divider pulse
	reg [5:0] presc_cnt_q; // Prescaler state
	reg presc_q; // Prescaler output pulse
	reg [12:0] fb_cnt_q; // Feedback counter state
	reg [5:0] swallow_left_q; // Remaining high-modulus cycles
	reg fb_div_q; // Feedback divider pulse
	wire ref_edge; // Qualified reference edge
	wire osc_edge; // Qualified oscillator edge
	wire [2:0] presc_code;
	wire ref_hold;
	wire fb_hold;
	wire dual_mod;
	wire [5:0] presc_mod;
	wire presc_term;
	wire fb_term;
	wire [13:0] ref_div;
	wire [12:0] fb_div;

	// Lower modulus for a prescaler code
	function [5:0] low_modulus;
		input [2:0] code;
		begin
			case (code)
				`PRESC_FIXED_1: low_modulus = 6'h01;
				`PRESC_DUAL_2_3: low_modulus = 6'h02;
				`PRESC_DUAL_2_3B: low_modulus = 6'h02;
				`PRESC_DUAL_4_5: low_modulus = 6'h04;
				`PRESC_DUAL_8_9: low_modulus = 6'h08;
				`PRESC_DUAL_16_17: low_modulus = 6'h10;
				`PRESC_DUAL_32_33: low_modulus = 6'h20;
				default: low_modulus = 6'h03;
			endcase
		end
	endfunction

	// Pin synchronisers for the two divider clock sources
	pin_edge_sync u_ref_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(ref_clk_i),
		.rise_o(ref_edge)
	);

	pin_edge_sync u_osc_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.pin_i(osc_clk_i),
		.rise_o(osc_edge)
	);

	// Register writes
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ref_low_q <= `RST_REF_COUNT_LOW;
			ref_high_q <= `RST_REF_COUNT_HIGH;
			swallow_q <= `RST_SWALLOW_COUNT;
			fb_low_q <= `RST_FEEDBACK_COUNT_LOW;
			fb_high_q <= `RST_FEEDBACK_COUNT_HIGH;
			ctrl_q <= `RST_DIVIDER_CONTROL;
			status_sel_q <= `RST_STATUS_PIN_SELECT;
		end else if (wr_en_i) begin
			if (addr_i == `ADDR_REF_COUNT_LOW) begin
				ref_low_q <= wr_data_i;
			end else if (addr_i == `ADDR_REF_COUNT_HIGH) begin
				ref_high_q <= wr_data_i[5:0];
			end else if (addr_i == `ADDR_SWALLOW_COUNT) begin
				swallow_q <= wr_data_i[5:0];
			end else if (addr_i == `ADDR_FEEDBACK_COUNT_LOW) begin
				fb_low_q <= wr_data_i;
			end else if (addr_i == `ADDR_FEEDBACK_COUNT_HIGH) begin
				fb_high_q <= wr_data_i[4:0];
			end else if (addr_i == `ADDR_DIVIDER_CONTROL) begin
				ctrl_q <= wr_data_i;
			end else if (addr_i == `ADDR_STATUS_PIN_SELECT) begin
				// Locked selector ignores writes
				if (!status_lock_i) begin
					status_sel_q <=
						wr_data_i[`STATUS_SEL_MSB:`STATUS_SEL_LSB];
				end
			end
		end
	end

	// Read decode, reserved bits zero
	always @* begin
		rd_data_d = 8'h00;
		if (addr_i == `ADDR_REF_COUNT_LOW) begin
			rd_data_d = ref_low_q;
		end else if (addr_i == `ADDR_REF_COUNT_HIGH) begin
			rd_data_d = {2'h0, ref_high_q};
		end else if (addr_i == `ADDR_SWALLOW_COUNT) begin
			rd_data_d = {2'h0, swallow_q};
		end else if (addr_i == `ADDR_FEEDBACK_COUNT_LOW) begin
			rd_data_d = fb_low_q;
		end else if (addr_i == `ADDR_FEEDBACK_COUNT_HIGH) begin
			rd_data_d = {3'h0, fb_high_q};
		end else if (addr_i == `ADDR_DIVIDER_CONTROL) begin
			rd_data_d = ctrl_q;
		end else if (addr_i == `ADDR_STATUS_PIN_SELECT) begin
			rd_data_d = {status_sel_q, 2'h0};
		end
	end

	// Registered read data
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			rd_data_q <= 8'h00;
		end else begin
			rd_data_q <= rd_data_d;
		end
	end

	// Control decode
	assign presc_code = ctrl_q[`CTRL_PRESC_MSB:`CTRL_PRESC_LSB];
	assign ref_hold = ctrl_q[`CTRL_RST_REF_BIT] |
		ctrl_q[`CTRL_RST_ALL_BIT];
	assign fb_hold = ctrl_q[`CTRL_RST_FB_BIT] |
		ctrl_q[`CTRL_RST_ALL_BIT];
	// Codes 000 and 111 are fixed divide
	assign dual_mod = (presc_code != `PRESC_FIXED_1) &&
		(presc_code != `PRESC_FIXED_3);
	// Higher modulus while swallow cycles remain
	assign presc_mod = low_modulus(presc_code) +
		((dual_mod && swallow_left_q != 6'h00) ? 6'h01 : 6'h00);
	assign presc_term = osc_edge && (presc_cnt_q == presc_mod - 6'h01);
	assign ref_div = ({ref_high_q, ref_low_q} == 14'h0000) ? 14'h0001 :
		{ref_high_q, ref_low_q};
	assign fb_div = ({fb_high_q, fb_low_q} == 13'h0000) ? 13'h0001 :
		{fb_high_q, fb_low_q};
	// Bypass ends the feedback count on every prescaler cycle
	assign fb_term = presc_term && (ctrl_q[`CTRL_BYPASS_BIT] ||
		fb_cnt_q == fb_div - 13'h0001);

	// Reference divider
	always @(posedge clk_i) begin
		if (sys_rst_i || ref_hold) begin
			ref_cnt_q <= 14'h0000;
			ref_div_q <= 1'b0;
		end else begin
			ref_div_q <= 1'b0;
			if (ref_edge) begin
				if (ref_cnt_q >= ref_div - 14'h0001) begin
					ref_cnt_q <= 14'h0000;
					ref_div_q <= 1'b1;
				end else begin
					ref_cnt_q <= ref_cnt_q + 14'h0001;
				end
			end
		end
	end

	// Prescaler and swallow/feedback counters
	always @(posedge clk_i) begin
		if (sys_rst_i || fb_hold) begin
			presc_cnt_q <= 6'h00;
			presc_q <= 1'b0;
			fb_cnt_q <= 13'h0000;
			// Preload swallow so the first period after a hold is full
			swallow_left_q <= (!sys_rst_i && dual_mod) ? swallow_q :
				6'h00;
			fb_div_q <= 1'b0;
		end else begin
			presc_q <= presc_term;
			fb_div_q <= fb_term;
			if (osc_edge) begin
				presc_cnt_q <= presc_term ? 6'h00 :
					presc_cnt_q + 6'h01;
			end
			if (fb_term) begin
				// Reload: low modulus times count plus swallow
				fb_cnt_q <= 13'h0000;
				swallow_left_q <= dual_mod ? swallow_q : 6'h00;
			end else if (presc_term) begin
				fb_cnt_q <= fb_cnt_q + 13'h0001;
				if (swallow_left_q != 6'h00) begin
					swallow_left_q <= swallow_left_q - 6'h01;
				end
			end
		end
	end

	// Outputs
	assign rd_data_o = rd_data_q;
	assign ref_div_o = ref_div_q;
	assign fb_div_o = fb_div_q;
	assign presc_out_o = presc_q;
	assign charge_pump_half_o = ctrl_q[`CTRL_CHARGE_PUMP_HALF_BIT];
	assign status_pin_sel_o = status_sel_q;
	// Ground for the default and all other selections here
	assign status_pin_o = 1'b0;
endmodule

// ==== bench/pll_fb_div_props.sv ====
// Checker for divider control port relations
`timescale 1ns/100ps
module pll_fb_div_props (
	input wire clk_i,
	input wire sys_rst_i,
	input wire wr_en_i,
	input wire [9:0] addr_i,
	input wire [7:0] wr_data_i,
	input wire [7:0] rd_data_o,
	input wire status_lock_i,
	input wire ref_div_o,
	input wire fb_div_o,
	input wire presc_out_o,
	input wire charge_pump_half_o,
	input wire [5:0] status_pin_sel_o,
	input wire status_pin_o
);
	reg [7:0] ctrl_q; // Shadow of divider control
	wire hold_r = ctrl_q[6] | ctrl_q[4]; // Reference held
	wire hold_n = ctrl_q[5] | ctrl_q[4]; // Feedback held
	wire wr_sel = wr_en_i && addr_i == 10'h017; // Selector write
	// Follow control writes
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			ctrl_q <= 8'h06;
		end else if (wr_en_i && addr_i == 10'h016) begin
			ctrl_q <= wr_data_i;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	// Control write, address held
	sequence ctrl_wr;
		wr_en_i && addr_i == 10'h016 ##1 addr_i == 10'h016;
	endsequence
	chk_pump_follow: assert property (
		wr_en_i && addr_i == 10'h016 |=>
		charge_pump_half_o == $past(wr_data_i[7])) else $error("pump");
	chk_ctrl_read: assert property (
		ctrl_wr |=> rd_data_o == $past(wr_data_i, 2)) else $error("rd");
	chk_sel_lock: assert property (
		wr_sel && status_lock_i |=> $stable(status_pin_sel_o))
		else $error("lock");
	chk_sel_write: assert property (
		wr_sel && !status_lock_i |=>
		status_pin_sel_o == $past(wr_data_i[7:2])) else $error("sel");
	chk_pin_ground: assert property (
		status_pin_sel_o == 6'h00 |-> !status_pin_o) else $error("gnd");
	chk_ref_hold: assert property (
		hold_r && $past(hold_r) && $past(hold_r, 2) |-> !ref_div_o)
		else $error("ref");
	chk_fb_hold: assert property (
		hold_n && $past(hold_n) && $past(hold_n, 2) |->
		!fb_div_o && !presc_out_o) else $error("fb");
	chk_all_hold: assert property (
		ctrl_q[4] [*3] |-> !ref_div_o && !fb_div_o) else $error("all");
endmodule

// ==== bench/pll_feedback_divider_control_tb.sv ====
// Self-checking bench for the divider control block
`timescale 1ns/100ps
`define CHK(a,b,m) begin total_checks++; if ((a) !== (b)) begin \
	err_total++; $display("unexpected %0t %s", $time, m); end end
module pll_feedback_divider_control_tb;
	reg clk_i = 0, sys_rst_i = 1, wr_en_i = 0, status_lock_i = 0;
	reg ref_clk_i = 0, osc_clk_i = 0; // Divider pins
	reg [9:0] addr_i = 0;
	reg [7:0] wr_data_i = 0;
	wire [7:0] rd_data_o;
	wire [5:0] status_pin_sel_o;
	wire ref_div_o, fb_div_o, presc_out_o, charge_pump_half_o, status_pin_o;
	integer err_total = 0, total_checks = 0, cyc = 0, n_ref = 0, n_fb = 0;
	integer i;
	integer n_pre = 0; // Prescaler pulses
	pll_feedback_divider_control uut (.clk_i, .sys_rst_i, .wr_en_i,
		.addr_i, .wr_data_i, .rd_data_o, .status_lock_i, .ref_clk_i,
		.osc_clk_i, .ref_div_o, .fb_div_o, .presc_out_o,
		.charge_pump_half_o, .status_pin_sel_o, .status_pin_o);
	// Clock
	initial forever #50 clk_i = ~clk_i;
	// Pulse counters and hang guard
	always @(posedge clk_i) begin
		cyc++;
		n_ref += ref_div_o;
		n_fb += fb_div_o;
		n_pre += presc_out_o;
		if (cyc > 20000) begin
			err_total++;
			stop_test;
		end
	end
	task stop_test;
		begin
			if (err_total == 0 && total_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// One-cycle register write
	task wr(input [9:0] a, input [7:0] d);
		begin
			@(negedge clk_i);
			wr_en_i = 1;
			addr_i = a;
			wr_data_i = d;
			@(negedge clk_i);
			wr_en_i = 0;
		end
	endtask
	// Registered read and compare
	task rchk(input [9:0] a, input [7:0] e);
		begin
			@(negedge clk_i);
			addr_i = a;
			@(negedge clk_i);
			`CHK(rd_data_o, e, "read")
		end
	endtask
	// Pin edges, three cycles high and low
	task edges(input integer n, input r, input o);
		begin
			repeat (n) begin
				@(negedge clk_i);
				ref_clk_i = r;
				osc_clk_i = o;
				repeat (3) @(negedge clk_i);
				ref_clk_i = 0;
				osc_clk_i = 0;
				repeat (2) @(negedge clk_i);
			end
			repeat (6) @(negedge clk_i);
		end
	endtask
	// Feedback ratio case from a clean restart
	task run(input [7:0] c, a, b, input integer m, x);
		begin
			wr(10'h013, a);
			wr(10'h014, b);
			wr(10'h016, c | 8'h20);
			wr(10'h016, c);
			n_fb = 0;
			n_pre = 0;
			edges(m, 0, 1);
			`CHK(n_fb, x, "fb count")
		end
	endtask
	initial begin
		repeat (8) @(negedge clk_i);
		sys_rst_i = 0;
		for (i = 0; i < 7; i++)
			rchk(10'h011 + i[9:0],
				8'(56'h01000003000600 >> (48 - 8 * i)));
		rchk(10'h018, 8'h00);
		wr(10'h013, 8'hff);
		rchk(10'h013, 8'h3f);
		wr(10'h015, 8'hff);
		rchk(10'h015, 8'h1f);
		wr(10'h015, 8'h00);
		wr(10'h016, 8'h80);
		`CHK(charge_pump_half_o, 1'b1, "charge pump")
		wr(10'h017, 8'hff);
		rchk(10'h017, 8'hfc);
		status_lock_i = 1;
		wr(10'h017, 8'h00);
		`CHK(status_pin_sel_o, 6'h3f, "locked")
		status_lock_i = 0;
		wr(10'h017, 8'h00);
		`CHK(status_pin_o, 1'b0, "ground")
		wr(10'h011, 8'h02);
		wr(10'h016, 8'h00);
		n_ref = 0;
		edges(6, 1, 0);
		`CHK(n_ref, 3, "ref")
		wr(10'h016, 8'h40);
		edges(4, 1, 0);
		`CHK(n_ref, 3, "ref hold")
		wr(10'h016, 8'h10);
		n_fb = 0;
		edges(4, 1, 1);
		`CHK(n_ref + n_fb, 3, "all hold")
		wr(10'h016, 8'h00);
		edges(4, 1, 0);
		`CHK(n_ref, 5, "ref restart")
		run(8'h00, 0, 3, 12, 4);
		run(8'h07, 0, 2, 12, 2);
		run(8'h0f, 0, 2, 12, 4);
		run(8'h04, 1, 2, 33, 1);
		run(8'h04, 0, 2, 33, 2);
		`CHK(n_pre, 4, "presc low")
		run(8'h05, 1, 1, 33, 1);
		`CHK(n_pre, 1, "presc high")
		run(8'h06, 1, 1, 32, 0);
		run(8'h24, 0, 3, 12, 0);
		// Mid-run reset restores defaults
		sys_rst_i = 1;
		repeat (2) @(negedge clk_i);
		sys_rst_i = 0;
		rchk(10'h011, 8'h01);
		rchk(10'h016, 8'h06);
		stop_test;
	end
endmodule
bind pll_feedback_divider_control pll_fb_div_props chk (.clk_i,
	.sys_rst_i, .wr_en_i, .addr_i, .wr_data_i, .rd_data_o, .status_lock_i,
	.ref_div_o, .fb_div_o, .presc_out_o, .charge_pump_half_o,
	.status_pin_sel_o, .status_pin_o);
